//--- rtl/dso_top.sv
// How it works
// - code 0: on while run command or output frequency nonzero
// - code 1: on for any fault except the two comm errors
// - code 2: on when frequency within width below the reference
// - code 3: on when frequency within width of detection level
// - code 4: on above level plus width, off below level, else hold
// - code 5: on below level plus width, off below level
// - code 6: on during automatic restart
// - code 9: on while output stage is baseblocked
// - code 12 over-torque, code 25 low-torque detection
// - code 13: on after current above threshold longer than duration
// - code 18: on when operation source setting is 3
// - code 19: follows the PLC logic result
// - code 20: on at zero speed
// - code 21: on when no fault and drive ready
// - code 22: on while bus voltage below low-voltage level
// - code 23: on in local operation source mode
// - code 24: on in local frequency source mode
// - code 26: on when frequency reference lost
// - reference loss: stop on setting 0, run at ratio on 1
// - code 27 follows timer, code 32 communication control
// - code 37: on while PID feedback lost
// - level accepts 0.0..400.0 Hz, width 0.1..25.5 Hz
module dso_top #(
  parameter int MS_CYCLES = dso_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // drive status, same clock
  input wire logic run_cmd,
  input wire logic [dso_pkg::FW-1:0] freq_out,
  input wire logic [dso_pkg::FW-1:0] freq_ref,
  input wire logic [dso_pkg::FW-1:0] out_current,
  input wire logic [dso_pkg::FW-1:0] dc_bus,
  input wire logic fault_other,
  input wire logic comm_error_a,
  input wire logic comm_error_b,
  input wire logic drive_ready,
  input wire logic restart_active,
  input wire logic baseblock,
  input wire logic over_torque,
  input wire logic low_torque,
  input wire logic plc_result,
  input wire logic zero_speed,
  input wire logic ref_loss,
  input wire logic timer_out,
  input wire logic pid_fb_loss,
  // terminal pins, first to last
  input wire logic [dso_pkg::NDIN-1:0] digital_inputs,
  // relay outputs
  output logic relay_output_one,
  output logic relay_output_two,
  output logic relay_output_three,
  // reference loss action
  output logic ref_loss_decel_q,
  output logic ref_loss_hold_q,
  output logic [dso_pkg::FW-1:0] ref_hold_freq_q
);
  import dso_pkg::*;

  logic [5:0] func_q [NOUT];
  logic [15:0] level_q;
  logic [7:0] width_q;
  logic [1:0] op_src_q;
  logic [1:0] fr_src_q;
  logic [NDIN-1:0] lr_mask_q;
  logic loss_act_q;
  logic [7:0] ratio_q;
  logic [15:0] cur_thr_q;
  logic [15:0] cur_dur_q;
  logic [15:0] lvolt_q;
  logic [NOUT-1:0] comm_ctl_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [NDIN-1:0] din_s1_q, din_s2_q, din_s3_q, din_q;
  logic hyst_q;
  logic [31:0] tick_cnt_q;
  logic ms_tick;
  logic [15:0] dur_cnt_q;
  logic [15:0] last_ref_q;
  logic [NOUT-1:0] relay;
  logic [63:0] cond;
  logic [31:0] wmerged;
  logic [31:0] rd_d;
  logic wr_en;
  logic [16:0] lvl_hi, lvl_lo, ref_lo;
  logic cur_over, cur_agree, local_op, local_fr, any_fault;
  logic [23:0] hold_prod;

  // write is taken on the edge where waitrequest is already low
  assign wr_en = avs_write && !wait_q;
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      wmerged[b*8 +: 8] = avs_byteenable[b] ? avs_writedata[b*8 +: 8]
                                            : rd_d[b*8 +: 8];
  end

  // one-cycle wait, then a single acknowledge cycle
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      wait_q <= 1'b1;
    else if ((avs_read || avs_write) && wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (avs_address)
      OFS_FUNC:
      begin
        for (int i = 0; i < NOUT; i++)
          rd_d[i*FUNC_STRIDE +: 6] = func_q[i];
      end
      OFS_FDET:
      begin
        rd_d[15:0] = level_q;
        rd_d[FDET_WID_LSB +: 8] = width_q;
      end
      OFS_SRC:
      begin
        rd_d[1:0] = op_src_q;
        rd_d[SRC_FSRC_LSB +: 2] = fr_src_q;
        rd_d[SRC_LRM_LSB +: NDIN] = lr_mask_q;
        rd_d[SRC_LACT_BIT] = loss_act_q;
        rd_d[SRC_RATIO_LSB +: 8] = ratio_q;
      end
      OFS_CUR:
      begin
        rd_d[15:0] = cur_thr_q;
        rd_d[CUR_DUR_LSB +: 16] = cur_dur_q;
      end
      OFS_LVOLT: rd_d[15:0] = lvolt_q;
      OFS_COMM: rd_d[NOUT-1:0] = comm_ctl_q;
      OFS_STAT:
      begin
        rd_d[NOUT-1:0] = relay;
        rd_d[STAT_HYST_BIT] = hyst_q;
        rd_d[STAT_CUR_BIT] = cur_agree;
        rd_d[STAT_LOP_BIT] = local_op;
        rd_d[STAT_LFR_BIT] = local_fr;
        rd_d[STAT_DIN_LSB +: NDIN] = din_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // read data captured while waiting, so it stands at the ack edge
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 32'h0000_0000;
    else if (avs_read && wait_q)
      rdata_q <= rd_d;
  end
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // per-output function codes
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      for (int i = 0; i < NOUT; i++)
        func_q[i] <= RST_FUNC;
    else if (wr_en && avs_address == OFS_FUNC)
      for (int i = 0; i < NOUT; i++)
        func_q[i] <= wmerged[i*FUNC_STRIDE +: 6];
  end

  // detection level and width, clamped to their accepted ranges
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      level_q <= RST_LEVEL;
      width_q <= RST_WIDTH;
    end
    else if (wr_en && avs_address == OFS_FDET)
    begin
      level_q <= (wmerged[15:0] > LEVEL_MAX) ? LEVEL_MAX
                                             : wmerged[15:0];
      width_q <= (wmerged[FDET_WID_LSB +: 8] < WIDTH_MIN) ? WIDTH_MIN
                 : wmerged[FDET_WID_LSB +: 8];
    end
  end

  // command sources and reference-loss settings
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      op_src_q <= RST_SRC;
      fr_src_q <= RST_SRC;
      lr_mask_q <= '0;
      loss_act_q <= 1'b0;
      ratio_q <= RST_RATIO;
    end
    else if (wr_en && avs_address == OFS_SRC)
    begin
      op_src_q <= wmerged[1:0];
      fr_src_q <= wmerged[SRC_FSRC_LSB +: 2];
      lr_mask_q <= wmerged[SRC_LRM_LSB +: NDIN];
      loss_act_q <= wmerged[SRC_LACT_BIT];
      ratio_q <= wmerged[SRC_RATIO_LSB +: 8];
    end
  end

  // current agree threshold/duration, low-voltage level, comm control
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cur_thr_q <= RST_CUR;
      cur_dur_q <= RST_CUR;
      lvolt_q <= RST_LVOLT;
      comm_ctl_q <= '0;
    end
    else if (wr_en)
    begin
      if (avs_address == OFS_CUR)
      begin
        cur_thr_q <= wmerged[15:0];
        cur_dur_q <= wmerged[CUR_DUR_LSB +: 16];
      end
      if (avs_address == OFS_LVOLT)
        lvolt_q <= wmerged[15:0];
      if (avs_address == OFS_COMM)
        comm_ctl_q <= wmerged[NOUT-1:0];
    end
  end

  // terminal pins: three flops, a change counts once stages 2 and 3 agree
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      din_s1_q <= '0;
      din_s2_q <= '0;
      din_s3_q <= '0;
      din_q <= '0;
    end
    else
    begin
      din_s1_q <= digital_inputs;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
      for (int i = 0; i < NDIN; i++)
        if (din_s2_q[i] == din_s3_q[i])
          din_q[i] <= din_s3_q[i];
    end
  end

  // frequency thresholds, widened so level plus width cannot wrap
  assign lvl_hi = {1'b0, level_q} + {9'h000, width_q};
  assign lvl_lo = ({1'b0, level_q} > {9'h000, width_q}) ?
                  {1'b0, level_q} - {9'h000, width_q} : 17'h00000;
  assign ref_lo = ({1'b0, freq_ref} > {9'h000, width_q}) ?
                  {1'b0, freq_ref} - {9'h000, width_q} : 17'h00000;

  // detection 1 hysteresis: the band between the thresholds holds state
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      hyst_q <= 1'b0;
    else if ({1'b0, freq_out} > lvl_hi)
      hyst_q <= 1'b1;
    else if (freq_out < level_q)
      hyst_q <= 1'b0;
  end

  // millisecond base; a long count, so the top exposes it for simulation
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      tick_cnt_q <= 32'h0000_0000;
    else if (ms_tick)
      tick_cnt_q <= 32'h0000_0000;
    else
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
  end
  assign ms_tick = (tick_cnt_q == 32'(MS_CYCLES - 1));

  // current above threshold for longer than the duration
  assign cur_over = out_current > cur_thr_q;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      dur_cnt_q <= 16'h0000;
    else if (!cur_over)
      dur_cnt_q <= 16'h0000;
    else if (ms_tick && dur_cnt_q != 16'hffff)
      dur_cnt_q <= dur_cnt_q + 16'h0001;
  end
  assign cur_agree = cur_over && (dur_cnt_q > cur_dur_q);

  // local/remote: source 0 or any mapped terminal active means local
  assign local_op = (op_src_q == SRC_LOCAL) || |(din_q & lr_mask_q);
  assign local_fr = (fr_src_q == SRC_LOCAL) || |(din_q & lr_mask_q);
  assign any_fault = fault_other || comm_error_a || comm_error_b;

  // condition per function code; unlisted codes stay zero
  always_comb
  begin
    cond = 64'h0000_0000_0000_0000;
    cond[FC_RUN] = run_cmd || (freq_out != '0);
    cond[FC_FAULT] = fault_other;
    cond[FC_FAGREE] = ({1'b0, freq_out} >= ref_lo) &&
                      (freq_out <= freq_ref);
    cond[FC_SAGREE] = ({1'b0, freq_out} >= lvl_lo) &&
                      ({1'b0, freq_out} <= lvl_hi);
    cond[FC_FDET1] = hyst_q;
    cond[FC_FDET2] = ({1'b0, freq_out} < lvl_hi) &&
                     (freq_out >= level_q);
    cond[FC_RESTART] = restart_active;
    cond[FC_BBLOCK] = baseblock;
    cond[FC_OTQ] = over_torque;
    cond[FC_LTQ] = low_torque;
    cond[FC_CAGREE] = cur_agree;
    cond[FC_PLCST] = (op_src_q == SRC_PLC);
    cond[FC_PLCCTL] = plc_result;
    cond[FC_ZSPD] = zero_speed;
    cond[FC_READY] = drive_ready && !any_fault;
    cond[FC_UVOLT] = dc_bus < lvolt_q;
    cond[FC_LOCOP] = local_op;
    cond[FC_LOCFR] = local_fr;
    cond[FC_REFLOSS] = ref_loss;
    cond[FC_TIMER] = timer_out;
    cond[FC_PIDLOSS] = pid_fb_loss;
  end

  // one selector per relay, each with its own code and comm bit
  genvar g;
  generate
    for (g = 0; g < NOUT; g++)
    begin : g_out
      logic [63:0] cond_g;
      always_comb
      begin
        cond_g = cond;
        cond_g[FC_COMM] = comm_ctl_q[g];
      end
      dso_sel u_sel (
        .mclk(mclk),
        .resetn(resetn),
        .code(func_q[g]),
        .cond(cond_g),
        .out_q(relay[g])
      );
    end
  endgenerate
  assign relay_output_one = relay[0];
  assign relay_output_two = relay[1];
  assign relay_output_three = relay[2];

  // last good reference is frozen while the reference is missing
  assign hold_prod = last_ref_q * ratio_q;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      last_ref_q <= '0;
      ref_loss_decel_q <= 1'b0;
      ref_loss_hold_q <= 1'b0;
      ref_hold_freq_q <= '0;
    end
    else
    begin
      if (!ref_loss)
        last_ref_q <= freq_ref;
      ref_loss_decel_q <= ref_loss && !loss_act_q;
      ref_loss_hold_q <= ref_loss && loss_act_q;
      ref_hold_freq_q <= 16'(hold_prod / {16'h0000, RATIO_DIV});
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_above_hi;
    {1'b0, freq_out} > lvl_hi;
  endsequence
  sequence s_below_lvl;
    freq_out < level_q;
  endsequence

  chk_run_relay: assert property (
    func_q[0] == FC_RUN |=>
    relay_output_one == $past(run_cmd || freq_out != '0))
    else $error("run relay does not follow run state");
  chk_fault_excl: assert property (
    func_q[1] == FC_FAULT && !fault_other |=> !relay_output_two)
    else $error("comm error drove the fault relay");
  chk_hyst_set: assert property (
    s_above_hi |=> hyst_q)
    else $error("detection 1 not set above level plus width");
  chk_hyst_clr: assert property (
    s_below_lvl ##1 s_below_lvl |-> !hyst_q)
    else $error("detection 1 not cleared below level");
  chk_hyst_hold: assert property (
    !({1'b0, freq_out} > lvl_hi) && !(freq_out < level_q) |=>
    $stable(hyst_q))
    else $error("detection 1 changed inside band");
  chk_cur_drop: assert property (
    !cur_over |=> dur_cnt_q == 16'h0000)
    else $error("current agree count survived a drop");
  chk_plc_src: assert property (
    func_q[0] == FC_PLCST |=>
    relay_output_one == $past(op_src_q == SRC_PLC))
    else $error("plc status relay wrong");
  chk_local_op: assert property (
    func_q[1] == FC_LOCOP && op_src_q == SRC_LOCAL |=> relay_output_two)
    else $error("source 0 not local");
  chk_loss_act: assert property (
    ref_loss && !loss_act_q |=> ref_loss_decel_q && !ref_loss_hold_q)
    else $error("reference loss action wrong");
  chk_level_range: assert property (
    level_q <= LEVEL_MAX && width_q >= WIDTH_MIN)
    else $error("detection setting out of range");
  chk_bus_ack: assert property (
    (avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus acknowledge not one cycle");
endmodule

//--- pkg/dso_pkg.sv
package dso_pkg;
  // frequency, current and voltage values travel in 0.1 units
  localparam int FW = 16;
  localparam int NOUT = 3;
  localparam int NDIN = 6;

  // register byte offsets
  localparam logic [5:0] OFS_FUNC = 6'h00;
  localparam logic [5:0] OFS_FDET = 6'h04;
  localparam logic [5:0] OFS_SRC = 6'h08;
  localparam logic [5:0] OFS_CUR = 6'h0c;
  localparam logic [5:0] OFS_LVOLT = 6'h10;
  localparam logic [5:0] OFS_COMM = 6'h14;
  localparam logic [5:0] OFS_STAT = 6'h18;

  // field positions
  localparam int FUNC_STRIDE = 8;
  localparam int FDET_WID_LSB = 16;
  localparam int SRC_FSRC_LSB = 4;
  localparam int SRC_LRM_LSB = 8;
  localparam int SRC_LACT_BIT = 16;
  localparam int SRC_RATIO_LSB = 24;
  localparam int CUR_DUR_LSB = 16;
  localparam int STAT_HYST_BIT = 3;
  localparam int STAT_CUR_BIT = 4;
  localparam int STAT_LOP_BIT = 5;
  localparam int STAT_LFR_BIT = 6;
  localparam int STAT_DIN_LSB = 8;

  // reset values
  localparam logic [5:0] RST_FUNC = 6'h00;
  localparam logic [15:0] RST_LEVEL = 16'h0000;
  localparam logic [7:0] RST_WIDTH = 8'h01;
  localparam logic [1:0] RST_SRC = 2'h0;
  localparam logic [7:0] RST_RATIO = 8'h64;
  localparam logic [15:0] RST_CUR = 16'h0000;
  localparam logic [15:0] RST_LVOLT = 16'h0000;

  // detection level 0.0..400.0 Hz, width 0.1..25.5 Hz
  localparam logic [15:0] LEVEL_MAX = 16'h0fa0;
  localparam logic [7:0] WIDTH_MIN = 8'h01;

  // command source settings
  localparam logic [1:0] SRC_LOCAL = 2'h0;
  localparam logic [1:0] SRC_PLC = 2'h3;
  localparam logic [7:0] RATIO_DIV = 8'h64;

  // output function codes
  localparam logic [5:0] FC_RUN = 6'h00;
  localparam logic [5:0] FC_FAULT = 6'h01;
  localparam logic [5:0] FC_FAGREE = 6'h02;
  localparam logic [5:0] FC_SAGREE = 6'h03;
  localparam logic [5:0] FC_FDET1 = 6'h04;
  localparam logic [5:0] FC_FDET2 = 6'h05;
  localparam logic [5:0] FC_RESTART = 6'h06;
  localparam logic [5:0] FC_BBLOCK = 6'h09;
  localparam logic [5:0] FC_OTQ = 6'h0c;
  localparam logic [5:0] FC_CAGREE = 6'h0d;
  localparam logic [5:0] FC_PLCST = 6'h12;
  localparam logic [5:0] FC_PLCCTL = 6'h13;
  localparam logic [5:0] FC_ZSPD = 6'h14;
  localparam logic [5:0] FC_READY = 6'h15;
  localparam logic [5:0] FC_UVOLT = 6'h16;
  localparam logic [5:0] FC_LOCOP = 6'h17;
  localparam logic [5:0] FC_LOCFR = 6'h18;
  localparam logic [5:0] FC_LTQ = 6'h19;
  localparam logic [5:0] FC_REFLOSS = 6'h1a;
  localparam logic [5:0] FC_TIMER = 6'h1b;
  localparam logic [5:0] FC_COMM = 6'h20;
  localparam logic [5:0] FC_PIDLOSS = 6'h25;

  // timing: one millisecond base for the current-agree duration
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
endpackage

//--- rtl/dso_sel.sv
module dso_sel (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // selection
  input wire logic [5:0] code,
  input wire logic [63:0] cond,
  // relay drive
  output logic out_q
);
  import dso_pkg::*;

  // reserved codes carry a zero condition bit, so they hold the relay off
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      out_q <= 1'b0;
    else
      out_q <= cond[code];
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_reserved_off: assert property (
    (code == 6'h07 || code == 6'h0a || code == 6'h0e || code == 6'h21)
    |=> !out_q)
    else $error("reserved code drove the relay");
endmodule

//--- tb/dso_relay_model.sv
module dso_relay_model (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // relay coils from the block
  input wire logic [2:0] coil,
  // contact state seen by outside circuitry
  output logic [2:0] contact_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // contacts lag the coil by a clock; open while held in reset
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      contact_q <= 3'h0;
    else
      contact_q <= coil;
  end
endmodule

//--- tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dso_pkg::*;
  logic mclk, resetn, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  // flags: run fault cea ceb rdy rst bb otq ltq plc zs loss tmr pid
  logic [13:0] flg;
  logic [FW-1:0] f_out, f_ref, cur, bus_v, hfreq;
  logic [NDIN-1:0] din;
  logic r1, r2, r3, dec, hold;
  logic [2:0] rel, contacts;
  int fails, checks_done;
  assign rel = {r3, r2, r1};

  dso_top #(.MS_CYCLES(10)) DUT (.mclk(mclk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .run_cmd(flg[0]),
    .freq_out(f_out), .freq_ref(f_ref), .out_current(cur), .dc_bus(bus_v),
    .fault_other(flg[1]), .comm_error_a(flg[2]), .comm_error_b(flg[3]),
    .drive_ready(flg[4]), .restart_active(flg[5]), .baseblock(flg[6]),
    .over_torque(flg[7]), .low_torque(flg[8]), .plc_result(flg[9]),
    .zero_speed(flg[10]), .ref_loss(flg[11]), .timer_out(flg[12]),
    .pid_fb_loss(flg[13]), .digital_inputs(din),
    .relay_output_one(r1), .relay_output_two(r2),
    .relay_output_three(r3), .ref_loss_decel_q(dec),
    .ref_loss_hold_q(hold), .ref_hold_freq_q(hfreq));
  dso_relay_model u_model (.mclk(mclk), .resetn(resetn), .coil(rel),
    .contact_q(contacts));

  task automatic give_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
      begin
        fails++;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
  endtask

  // one avalon transfer; request held until waitrequest seen low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
      begin
        fails++;
        $display("[FAIL] %0t bus answer never came", $time);
        give_verdict();
      end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic codes(input logic [5:0] a, b, c);
    bus(1'b1, OFS_FUNC, {10'h000, c, 2'h0, b, 2'h0, a});
  endtask

  // drive flags and output frequency, let the relays settle
  task automatic drv(input logic [13:0] f, input logic [15:0] fo);
    @(posedge mclk);
    flg <= f;
    f_out <= fo;
    tick(4);
  endtask

  task automatic t_regs;
    bus(1'b0, OFS_FUNC, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, OFS_FDET, 32'h0);
    chk(q, {8'h00, RST_WIDTH, RST_LEVEL});
    bus(1'b0, OFS_SRC, 32'h0);
    chk(q, {RST_RATIO, 24'h000000});
    bus(1'b1, 6'h1c, 32'hffffffff);
    bus(1'b0, 6'h1c, 32'h0);
    chk(q, 32'h0);
    // status is read-only; local op and local freq set at reset
    bus(1'b1, OFS_STAT, 32'hffffffff);
    bus(1'b0, OFS_STAT, 32'h0);
    chk(q, 32'h00000060);
  endtask

  task automatic t_run;
    codes(FC_RUN, FC_RUN, FC_RUN);
    drv(14'h0001, 16'h0000);
    chk(rel, 3'h7);
    chk(contacts, 3'h7);
    drv(14'h0000, 16'h0005);
    chk(rel, 3'h7);
    drv(14'h0000, 16'h0000);
    chk(rel, 3'h0);
  endtask

  task automatic t_fault;
    codes(FC_FAULT, FC_FAULT, FC_READY);
    drv(14'h001c, 16'h0000);
    chk(rel, 3'h0);
    drv(14'h0010, 16'h0000);
    chk(rel, 3'h4);
    drv(14'h0012, 16'h0000);
    chk(rel, 3'h3);
  endtask

  // one code per plain status flag
  task automatic t_flags;
    logic [5:0] c[9];
    c = '{FC_RESTART, FC_BBLOCK, FC_OTQ, FC_LTQ, FC_PLCCTL, FC_ZSPD,
          FC_REFLOSS, FC_TIMER, FC_PIDLOSS};
    for (int i = 0; i < 9; i++)
    begin
      codes(c[i], c[i], c[i]);
      drv(14'h0020 << i, 16'h0000);
      chk(rel, 3'h7);
      drv(14'h0000, 16'h0000);
      chk(rel, 3'h0);
    end
  endtask

  task automatic t_freq;
    bus(1'b1, OFS_FDET, 32'h00140064);
    codes(FC_FDET1, FC_SAGREE, FC_FDET2);
    drv(14'h0000, 16'h0082);
    chk(rel, 3'h1);
    drv(14'h0000, 16'h006e);
    chk(rel, 3'h7);
    drv(14'h0000, 16'h005a);
    chk(rel, 3'h2);
    drv(14'h0000, 16'h006e);
    chk(rel, 3'h6);
    codes(FC_FAGREE, FC_FAGREE, FC_FAGREE);
    f_ref <= 16'h01f4;
    drv(14'h0000, 16'h01ea);
    chk(rel, 3'h7);
    drv(14'h0000, 16'h01d6);
    chk(rel, 3'h0);
    // width 0 acts as 0.1 Hz, level clamps at 400.0 Hz
    bus(1'b1, OFS_FDET, 32'h00000064);
    codes(FC_SAGREE, FC_SAGREE, FC_SAGREE);
    drv(14'h0000, 16'h0065);
    chk(rel, 3'h7);
    bus(1'b1, OFS_FDET, 32'h00011388);
    codes(FC_FDET1, FC_FDET1, FC_FDET1);
    drv(14'h0000, 16'h0fa2);
    chk(rel, 3'h7);
    drv(14'h0000, 16'h0000);
  endtask

  task automatic t_cur;
    bus(1'b1, OFS_CUR, 32'h00020032);
    codes(FC_CAGREE, FC_CAGREE, FC_CAGREE);
    @(posedge mclk);
    cur <= 16'h003c;
    tick(15);
    chk(rel, 3'h0);
    tick(30);
    chk(rel, 3'h7);
    @(posedge mclk);
    cur <= 16'h0000;
    tick(4);
    chk(rel, 3'h0);
  endtask

  task automatic t_src;
    codes(FC_PLCST, FC_LOCOP, FC_LOCFR);
    bus(1'b1, OFS_SRC, 32'h64000003);
    tick(4);
    chk(rel, 3'h5);
    bus(1'b1, OFS_SRC, 32'h64000011);
    tick(4);
    chk(rel, 3'h0);
    bus(1'b1, OFS_SRC, 32'h64000111);
    din <= 6'h01;
    tick(8);
    chk(rel, 3'h6);
    @(posedge mclk);
    din <= 6'h00;
  endtask

  task automatic t_volt;
    bus(1'b1, OFS_LVOLT, 32'h00000064);
    bus(1'b1, OFS_COMM, 32'h00000004);
    codes(FC_UVOLT, FC_UVOLT, FC_COMM);
    bus_v <= 16'h0063;
    tick(4);
    chk(rel, 3'h7);
    bus(1'b1, OFS_COMM, 32'h00000000);
    bus_v <= 16'h0064;
    tick(4);
    chk(rel, 3'h0);
  endtask

  task automatic t_loss;
    @(posedge mclk);
    f_ref <= 16'h03e8;
    bus(1'b1, OFS_SRC, 32'h32000000);
    drv(14'h0800, 16'h0000);
    chk({dec, hold}, 2'h2);
    bus(1'b1, OFS_SRC, 32'h32010000);
    tick(4);
    chk({dec, hold}, 2'h1);
    chk(hfreq, 16'h01f4);
    drv(14'h0000, 16'h0000);
  endtask

  task automatic t_rsv;
    codes(6'h07, FC_RUN, 6'h26);
    drv(14'h0001, 16'h0000);
    chk(rel, 3'h2);
    codes(6'h0e, 6'h1c, 6'h21);
    tick(4);
    chk(rel, 3'h0);
  endtask

  // free-running clock at 125 MHz
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial
  begin
    resetn = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {flg, f_out, f_ref, cur, bus_v, din} = '0;
    fails = 0;
    checks_done = 0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_run();
    t_fault();
    t_flags();
    t_freq();
    t_cur();
    t_src();
    t_volt();
    t_loss();
    t_rsv();
    give_verdict();
  end
endmodule
